/* File: include/fsr_pkg.sv */
// Constants for the firmware semaphore and status register block
package fsr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] FW_STATUS_OFF = 16'h0010;  // Firmware side, read/write
    localparam logic [15:0] HOST_COPY_OFF = 16'h5B54;  // Host side, read-only copy
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GRANT_BIT = 0;   // Firmware grant flag
    localparam int WAKE_BIT = 1;    // Engine caused host wake
    localparam int RMGMT_BIT = 2;   // Remote management support
    localparam int PROXY_BIT = 3;   // Network proxy support
    localparam int MSGCAP_BIT = 4;  // Engine messaging capable
    localparam int SRVREQ_BIT = 5;  // Engine service request
    localparam int PHYRST_BIT = 6;  // PHY reset on host reset
    localparam int VALID_BIT = 15;  // Firmware valid
    localparam int FLAG_LO = 1;     // Plain firmware flags span bits 1..6
    localparam int FLAG_HI = 6;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] FLAGS_RST = 6'h20;  // Bit 6 resets to one, bits 1..5 to zero
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
endpackage

/* File: include/fsr_arb_if.sv */
// Grant arbitration signals between the register top and the arbiter
`timescale 1ns/1ps
interface fsr_arb_if;
    logic fw_request;   // Firmware wants the shared resources
    logic sw_claim;     // Host software claim flag is set
    logic mdio_busy;    // Hardware MDIO access in progress
    logic grant;        // Firmware holds the shared resources
    modport arb (input fw_request, input sw_claim, input mdio_busy, output grant);
    modport user (output fw_request, output sw_claim, output mdio_busy, input grant);
endinterface

/* File: verilog/fsr_grant_arb.sv */
// Arbiter that turns a firmware request into the firmware grant flag
`timescale 1ns/1ps
module fsr_grant_arb (
    // Clock and power-good reset
    input wire logic core_clk,
    input wire logic nrst,
    // Arbitration signals
    fsr_arb_if.arb arb
);
    // ------------------------------------------------------------
    // Grant flop
    // ------------------------------------------------------------
    logic grant;        // Current grant
    logic next_grant;   // Grant for the next cycle
    logic res_free;     // Neither software nor hardware uses the resources

    assign res_free = !arb.sw_claim && !arb.mdio_busy;
    // Once held, the grant stays until firmware withdraws; a late claim cannot steal it
    assign next_grant = arb.fw_request && (grant || res_free); // see (R4) see (R17)
    assign arb.grant = grant;

    // Grant register, reset only by power-good
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            grant <= 1'b0;
        end else begin
            grant <= next_grant;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_grant_needs_free: assert property (@(posedge core_clk) disable iff (!nrst) // see (R4)
        $rose(grant) |-> $past(res_free) && $past(arb.fw_request))
        else $error("grant rose while resources were busy");
    a_grant_stays_held: assert property (@(posedge core_clk) disable iff (!nrst) // see (R17)
        grant && arb.fw_request |=> grant)
        else $error("grant lost while firmware still requested");
    a_grant_released: assert property (@(posedge core_clk) disable iff (!nrst) // see (R6)
        !arb.fw_request |=> !grant)
        else $error("grant kept after firmware withdrew");
endmodule

/* File: verilog/fsr_top.sv */
// Firmware semaphore and status register with its read-only host copy
//
// Operation
// (R1) Host sees read-only copy of the register
// (R2) Only power-good reset restores the register
// (R3) Grant flag: firmware writes, host only reads
// (R4) Grant only when claim clear, MDIO idle
// (R5) Firmware sets grant, polls, then accesses
// (R6) Firmware clears grant when access completes
// (R7) Bit 1 records engine caused host wake
// (R8) Firmware clears wake flag before sleep
// (R9) Bit 2 remote management, valid with valid-bit
// (R10) Bit 3 network proxy, valid with valid-bit
// (R11) Bit 4 engine mailbox messaging capable
// (R12) Bit 5 engine asks driver release mailbox
// (R13) Bit 6 resets one; enables PHY reinit
// (R14) Firmware clears bit 6 to keep link
// (R15) Management reset clears valid; firmware sets it
// (R16) Bits 0..5 reset zero; host writes ignored
// (R17) Grant held blocks MDIO and host claims
`timescale 1ns/1ps
module fsr_top #(
    parameter int ADDR_W = 16  // Register address width
) (
    // Clock and LAN power-good reset
    input wire logic core_clk,
    input wire logic nrst,
    // Firmware register port
    input wire logic fw_sel,
    input wire logic fw_wr,
    input wire logic [ADDR_W-1:0] fw_addr,
    input wire logic [31:0] fw_wdata,
    output logic [31:0] fw_rdata,
    // Host register port
    input wire logic host_sel,
    input wire logic host_wr,
    input wire logic [ADDR_W-1:0] host_addr,
    input wire logic [31:0] host_wdata,
    output logic [31:0] host_rdata,
    // Neighbouring state and reset events
    input wire logic software_claim_flag,
    input wire logic hw_mdio_busy,
    input wire logic mgmt_reset,
    input wire logic host_bus_reset,
    input wire logic sw_phy_reset,
    // Arbitration and PHY outputs
    output logic firmware_grant_flag,
    output logic mdio_hold,
    output logic claim_refuse,
    output logic phy_device_reset
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    // The host copy offset needs fifteen address bits
    // A narrower bus could never reach the host copy; a wider one would alias nothing useful
    if (ADDR_W < 15 || ADDR_W > 16) begin : g_bad_width
        $error("ADDR_W must be 15 or 16");
    end

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [fsr_pkg::FLAG_HI:fsr_pkg::FLAG_LO] flags;  // Firmware flags, bits 1..6
    logic firmware_valid;   // Firmware boot complete
    logic fw_request;       // Firmware asked for the grant
    logic grant;            // Grant from arbiter
    logic [31:0] status;    // Assembled register image

    // Arbitration signals travel bundled to the arbiter
    fsr_arb_if arb_bus ();

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire fw_hit = fw_sel && (fw_addr == fsr_pkg::FW_STATUS_OFF[ADDR_W-1:0]);
    wire fw_write = fw_hit && fw_wr;
    wire fw_read = fw_hit && !fw_wr;
    wire host_hit = host_sel && (host_addr == fsr_pkg::HOST_COPY_OFF[ADDR_W-1:0]);
    wire host_read = host_hit && !host_wr;
    // Bit 0 reads back the actual grant, not the request, so polling firmware sees the truth
    // Host writes decode to nothing: no path from host_wdata into storage. see (R16)
    wire phy_reinit = flags[fsr_pkg::PHYRST_BIT] && (host_bus_reset || sw_phy_reset);

    // Next values
    wire next_request = fw_write ? fw_wdata[fsr_pkg::GRANT_BIT] : fw_request; // see (R3)
    wire [fsr_pkg::FLAG_HI:fsr_pkg::FLAG_LO] next_flags =
        fw_write ? fw_wdata[fsr_pkg::FLAG_HI:fsr_pkg::FLAG_LO] : flags;
    // Management reset wins over a same-cycle firmware write: boot must redo it
    wire next_valid = mgmt_reset ? 1'b0 :
        (fw_write ? fw_wdata[fsr_pkg::VALID_BIT] : firmware_valid); // see (R15)

    // Register image; capability bits are stored as written, readers gate them
    always_comb begin
        status = fsr_pkg::DATA_ZERO;
        status[fsr_pkg::GRANT_BIT] = grant; // see (R4)
        status[fsr_pkg::FLAG_HI:fsr_pkg::FLAG_LO] = flags; // see (R7) see (R11) see (R12)
        status[fsr_pkg::VALID_BIT] = firmware_valid; // see (R9) see (R10)
    end

    // ------------------------------------------------------------
    // Arbiter
    // ------------------------------------------------------------
    assign arb_bus.fw_request = fw_request;
    assign arb_bus.sw_claim = software_claim_flag;
    assign arb_bus.mdio_busy = hw_mdio_busy;
    assign grant = arb_bus.grant;

    fsr_grant_arb u_arb (
        .core_clk (core_clk),
        .nrst (nrst),
        .arb (arb_bus)
    );

    // The arbiter grant is itself a flop, so these outputs are registered
    assign firmware_grant_flag = grant;
    assign mdio_hold = grant;     // see (R17)
    assign claim_refuse = grant;  // see (R17)

    // ------------------------------------------------------------
    // Register storage, reset only by LAN power-good
    // ------------------------------------------------------------
    // Host bus and software resets never reach these flops
    always_ff @(posedge core_clk or negedge nrst) begin // see (R2)
        if (!nrst) begin
            flags <= fsr_pkg::FLAGS_RST; // see (R13) see (R16)
            firmware_valid <= 1'b0;
            fw_request <= 1'b0;
        end else begin
            flags <= next_flags;
            firmware_valid <= next_valid;
            fw_request <= next_request;
        end
    end

    // ------------------------------------------------------------
    // Read ports and PHY reset pulse
    // ------------------------------------------------------------
    // Read data returns one cycle after the access, zero when not addressed
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fw_rdata <= fsr_pkg::DATA_ZERO;
            host_rdata <= fsr_pkg::DATA_ZERO;
            phy_device_reset <= 1'b0;
        end else begin
            fw_rdata <= fw_read ? status : fsr_pkg::DATA_ZERO;
            host_rdata <= host_read ? status : fsr_pkg::DATA_ZERO; // see (R1)
            phy_device_reset <= phy_reinit; // see (R13)
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fw_grant_req;
        fw_write && fw_wdata[fsr_pkg::GRANT_BIT] && !grant;
    endsequence
    sequence s_res_free_now;
        !software_claim_flag && !hw_mdio_busy;
    endsequence

    a_host_copy_match: assert property (@(posedge core_clk) disable iff (!nrst) // see (R1)
        host_read |=> host_rdata == $past(status))
        else $error("host copy differs from register");
    a_host_write_void: assert property (@(posedge core_clk) disable iff (!nrst) // see (R16)
        host_sel && host_wr && !fw_write && !mgmt_reset |=> $stable(flags) && $stable(fw_request))
        else $error("host write changed register");
    a_grant_after_req: assert property (@(posedge core_clk) disable iff (!nrst) // see (R4)
        s_fw_grant_req ##1 (s_res_free_now and fw_request) |=> grant)
        else $error("free resources not granted");
    a_grant_blocked: assert property (@(posedge core_clk) disable iff (!nrst) // see (R4)
        !grant && (software_claim_flag || hw_mdio_busy) |=> !grant)
        else $error("grant taken while resources busy");
    a_phy_reinit_on: assert property (@(posedge core_clk) disable iff (!nrst) // see (R13)
        phy_reinit |=> phy_device_reset ##1 !$past(phy_reinit) || phy_device_reset)
        else $error("PHY reinit pulse missing");
    a_phy_reinit_off: assert property (@(posedge core_clk) disable iff (!nrst) // see (R13)
        !flags[fsr_pkg::PHYRST_BIT] |=> !phy_device_reset)
        else $error("PHY reinit while disabled");
    a_valid_cleared: assert property (@(posedge core_clk) disable iff (!nrst) // see (R15)
        mgmt_reset |=> !firmware_valid && !status[fsr_pkg::VALID_BIT])
        else $error("valid bit survived management reset");
    a_hold_follows: assert property (@(posedge core_clk) disable iff (!nrst) // see (R17)
        grant && fw_request |=> mdio_hold && claim_refuse)
        else $error("hold dropped while grant held");

    // ------------------------------------------------------------
    // Register checks
    // ------------------------------------------------------------
    // A reset event while the PHY bit is set
    sequence s_phy_event;
        flags[fsr_pkg::PHYRST_BIT] && (host_bus_reset || sw_phy_reset);
    endsequence
    // The PHY reset output standing high
    sequence s_phy_pulse;
        phy_device_reset;
    endsequence

    // Nothing but a firmware write may move the flags or the grant request, whatever resets occur
    a_flags_kept: assert property (@(posedge core_clk) disable iff (!nrst) // see (R2)
        !fw_write |=> $stable(flags) && $stable(fw_request))
        else $error("stored bits moved without a firmware write");
    // Firmware reads the same image that the host copy shows
    a_fw_copy_match: assert property (@(posedge core_clk) disable iff (!nrst) // see (R3)
        fw_read |=> fw_rdata == $past(status))
        else $error("firmware read differs from register");
    // Idle read data is zero so a stale image never lingers on the host bus
    a_read_idle_zero: assert property (@(posedge core_clk) disable iff (!nrst) // see (R1)
        !host_read |=> host_rdata == fsr_pkg::DATA_ZERO)
        else $error("host read data not zero when idle");
    a_flag_write_lands: assert property (@(posedge core_clk) disable iff (!nrst) // see (R12)
        fw_write |=> flags == $past(fw_wdata[fsr_pkg::FLAG_HI:fsr_pkg::FLAG_LO]))
        else $error("firmware flag write lost");
    a_valid_from_write: assert property (@(posedge core_clk) disable iff (!nrst) // see (R15)
        fw_write && !mgmt_reset |=> firmware_valid == $past(fw_wdata[fsr_pkg::VALID_BIT]))
        else $error("valid bit write lost");
    // Every PHY event gives a pulse, and every pulse has an event behind it
    a_phy_event_pulse: assert property (@(posedge core_clk) disable iff (!nrst) // see (R13)
        s_phy_event |=> s_phy_pulse)
        else $error("PHY reset event gave no pulse");
    a_phy_pulse_cause: assert property (@(posedge core_clk) disable iff (!nrst) // see (R13)
        s_phy_pulse |-> $past(phy_reinit))
        else $error("PHY pulse without a reset event");
endmodule

/* File: verif/fsr_host_model.sv */
// Host driver and hardware MDIO model facing the semaphore block
`timescale 1ns/1ps
module fsr_host_model (
    // Clock and power-good reset
    input wire logic core_clk,
    input wire logic nrst,
    // Wishes from the bench
    input wire logic want_claim,
    input wire logic want_mdio,
    // Hold-off outputs of the block
    input wire logic claim_refuse,
    input wire logic mdio_hold,
    // Levels seen by the block
    output logic software_claim_flag,
    output logic hw_mdio_busy
);
    // A claim or MDIO cycle starts only when not held off; once started it runs on,
    // which is the awkward case for the arbiter
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            software_claim_flag <= 1'h0;
            hw_mdio_busy <= 1'h0;
        end else begin
            software_claim_flag <= want_claim & (software_claim_flag | ~claim_refuse);
            hw_mdio_busy <= want_mdio & (hw_mdio_busy | ~mdio_hold);
        end
    end
endmodule

/* File: verif/fsr_top_tb.sv */
// Self-checking bench for the firmware semaphore and status register
`timescale 1ns/1ps
module fsr_top_tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic core_clk = 1'h0, nrst = 1'h0, fw_sel = 1'h0, fw_wr = 1'h0, host_sel = 1'h0;
    logic host_wr = 1'h0, mgmt_reset = 1'h0, host_bus_reset = 1'h0, sw_phy_reset = 1'h0;
    logic want_claim = 1'h0, want_mdio = 1'h0;
    logic [15:0] fw_addr = 16'h0000, host_addr = 16'h0000;
    logic [31:0] fw_wdata = 32'h0000_0000, host_wdata = 32'h0000_0000, fw_rdata, host_rdata, q;
    logic software_claim_flag, hw_mdio_busy, firmware_grant_flag, mdio_hold, claim_refuse;
    logic phy_device_reset;
    int n_errors = 0, tests_run = 0;
    // 50 MHz clock
    always #10 core_clk = ~core_clk;
    fsr_top fsr_top_i (.core_clk(core_clk), .nrst(nrst), .fw_sel(fw_sel), .fw_wr(fw_wr),
        .fw_addr(fw_addr), .fw_wdata(fw_wdata), .fw_rdata(fw_rdata), .host_sel(host_sel),
        .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .software_claim_flag(software_claim_flag),
        .hw_mdio_busy(hw_mdio_busy), .mgmt_reset(mgmt_reset), .host_bus_reset(host_bus_reset),
        .sw_phy_reset(sw_phy_reset), .firmware_grant_flag(firmware_grant_flag),
        .mdio_hold(mdio_hold), .claim_refuse(claim_refuse), .phy_device_reset(phy_device_reset));
    fsr_host_model fsr_host_model_i (.core_clk(core_clk), .nrst(nrst), .want_claim(want_claim),
        .want_mdio(want_mdio), .claim_refuse(claim_refuse), .mdio_hold(mdio_hold),
        .software_claim_flag(software_claim_flag), .hw_mdio_busy(hw_mdio_busy));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask
    // One access on either port; read data is taken half a cycle after the taking edge
    task automatic acc(input logic h, input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(negedge core_clk);
        {fw_sel, host_sel, fw_wr, host_wr} = {~h, h, wr & ~h, wr & h};
        {fw_addr, host_addr, fw_wdata, host_wdata} = {a, a, d, d};
        @(negedge core_clk);
        {fw_sel, host_sel, fw_wr, host_wr} = 4'h0;
        q = h ? host_rdata : fw_rdata;
    endtask
    // Bounded wait for the grant level; running out ends the run
    task automatic wait_grant(input logic exp);
        int i;
        for (i = 0; i < 10 && firmware_grant_flag !== exp; i++) @(negedge core_clk);
        chk("grant", {31'h0, firmware_grant_flag}, {31'h0, exp});
        if (firmware_grant_flag !== exp) final_report();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_and_map();
        acc(1'h0, 1'h0, fsr_pkg::FW_STATUS_OFF, 32'h0);
        chk("fw rst", q, 32'h0000_0040);
        @(negedge core_clk);
        chk("fw rdata end", fw_rdata, 32'h0000_0000);
        acc(1'h1, 1'h0, fsr_pkg::HOST_COPY_OFF, 32'h0);
        chk("host rst", q, 32'h0000_0040);
        acc(1'h0, 1'h0, 16'h0014, 32'h0);
        chk("fw unmapped", q, 32'h0000_0000);
        acc(1'h1, 1'h0, 16'h5B50, 32'h0);
        chk("host unmapped", q, 32'h0000_0000);
    endtask
    task automatic t_grant();
        want_claim = 1'h1;
        repeat (3) @(negedge core_clk);
        acc(1'h0, 1'h1, fsr_pkg::FW_STATUS_OFF, 32'h0000_0041);
        repeat (4) @(negedge core_clk);
        chk("no grant on claim", {31'h0, firmware_grant_flag}, 32'h0);
        want_claim = 1'h0;
        wait_grant(1'h1);
        acc(1'h0, 1'h0, fsr_pkg::FW_STATUS_OFF, 32'h0);
        chk("fw grant", q, 32'h0000_0041);
        acc(1'h1, 1'h0, fsr_pkg::HOST_COPY_OFF, 32'h0);
        chk("host grant", q, 32'h0000_0041);
        {want_claim, want_mdio} = 2'h3;
        repeat (4) @(negedge core_clk);
        chk("held", {firmware_grant_flag, mdio_hold, claim_refuse}, 32'h7);
        acc(1'h0, 1'h1, fsr_pkg::FW_STATUS_OFF, 32'h0000_0040);
        wait_grant(1'h0);
        repeat (3) @(negedge core_clk);
        acc(1'h0, 1'h1, fsr_pkg::FW_STATUS_OFF, 32'h0000_0041);
        want_claim = 1'h0;
        repeat (4) @(negedge core_clk);
        chk("no grant on mdio", {31'h0, firmware_grant_flag}, 32'h0);
        want_mdio = 1'h0;
        wait_grant(1'h1);
        acc(1'h0, 1'h1, fsr_pkg::FW_STATUS_OFF, 32'h0000_0040);
        wait_grant(1'h0);
        // Resources free: the grant follows the request by exactly one cycle
        acc(1'h0, 1'h1, fsr_pkg::FW_STATUS_OFF, 32'h0000_0041);
        chk("grant early", {31'h0, firmware_grant_flag}, 32'h0);
        @(negedge core_clk);
        chk("grant on time", {31'h0, firmware_grant_flag}, 32'h1);
        acc(1'h0, 1'h1, fsr_pkg::FW_STATUS_OFF, 32'h0000_0040);
        wait_grant(1'h0);
        chk("hold off", {30'h0, mdio_hold, claim_refuse}, 32'h0);
    endtask
    task automatic t_flags();
        int b;
        for (b = 1; b <= 5; b++) begin
            acc(1'h0, 1'h1, fsr_pkg::FW_STATUS_OFF, 32'h0000_8040 | (32'h1 << b));
            acc(1'h1, 1'h0, fsr_pkg::HOST_COPY_OFF, 32'h0);
            chk("flag copy", q, 32'h0000_8040 | (32'h1 << b));
        end
        chk("wake clr", {31'h0, q[fsr_pkg::WAKE_BIT]}, 32'h0);
        acc(1'h1, 1'h1, fsr_pkg::HOST_COPY_OFF, 32'hFFFF_FFFF);
        acc(1'h1, 1'h0, fsr_pkg::HOST_COPY_OFF, 32'h0);
        chk("host write void", q, 32'h0000_8060);
        {host_bus_reset, sw_phy_reset} = 2'h3;
        @(negedge core_clk);
        {host_bus_reset, sw_phy_reset} = 2'h0;
        acc(1'h0, 1'h0, fsr_pkg::FW_STATUS_OFF, 32'h0);
        chk("kept", q, 32'h0000_8060);
        mgmt_reset = 1'h1;
        @(negedge core_clk);
        mgmt_reset = 1'h0;
        acc(1'h0, 1'h0, fsr_pkg::FW_STATUS_OFF, 32'h0);
        chk("valid clr", q, 32'h0000_0060);
    endtask
    // Power-good in mid-run brings the PHY bit back to one
    task automatic t_power_good();
        @(negedge core_clk);
        nrst = 1'h0;
        repeat (4) @(negedge core_clk);
        nrst = 1'h1;
        acc(1'h1, 1'h0, fsr_pkg::HOST_COPY_OFF, 32'h0);
        chk("power good", q, 32'h0000_0040);
    endtask
    // Each reset event with the PHY bit set, then with it cleared
    task automatic t_phy();
        int i;
        for (i = 0; i < 4; i++) begin
            if (i == 2) acc(1'h0, 1'h1, fsr_pkg::FW_STATUS_OFF, 32'h0000_0000);
            @(negedge core_clk);
            {host_bus_reset, sw_phy_reset} = i[0] ? 2'h1 : 2'h2;
            @(negedge core_clk);
            {host_bus_reset, sw_phy_reset} = 2'h0;
            chk("phy rst", {31'h0, phy_device_reset}, {31'h0, i < 2});
            @(negedge core_clk);
            chk("phy rst end", {31'h0, phy_device_reset}, 32'h0);
        end
    endtask
    initial begin
        repeat (4) @(negedge core_clk);
        nrst = 1'h1;
        t_reset_and_map();
        t_grant();
        t_flags();
        t_phy();
        t_power_good();
        final_report();
    end
endmodule
